// ---- src/osos_pkg.sv ----
package osos_pkg;
  // register byte offsets
  localparam logic [11:0] OSOS_CTRL_OFS = 12'h000;
  localparam logic [11:0] OSOS_STAT_OFS = 12'h004;
  localparam logic [11:0] OSOS_TXDATA_OFS = 12'h008;
  localparam logic [11:0] OSOS_RXDATA_OFS = 12'h00C;
  // control and status field positions
  localparam int OSOS_TXE_LSB = 0;
  localparam int OSOS_TXINV_BIT = 2;
  localparam int OSOS_RXINV_BIT = 3;
  localparam int OSOS_MOD_BIT = 4;
  localparam int OSOS_FDC_LSB = 5;
  localparam int OSOS_STAT_SLOTS_LSB = 0;
  localparam int OSOS_STAT_RXVAL_BIT = 2;
  localparam int OSOS_STAT_BATT_BIT = 3;
  localparam int OSOS_STAT_RX_BIT = 4;
  // reset value: pin disabled (field 11), no inversion, no carrier, 50%
  localparam logic [6:0] OSOS_CTRL_RST = 7'h03;
  localparam logic [1:0] OSOS_TXE_ACTIVE = 2'h0;
  // carrier timing
  localparam int OSOS_CLK_HZ = 100_000_000;
  localparam int OSOS_CARRIER_HZ = 38_000;
  localparam int OSOS_CARRIER_CYC = OSOS_CLK_HZ / OSOS_CARRIER_HZ;
  // duty codes
  localparam logic [1:0] OSOS_DUTY_50 = 2'h0;
  localparam logic [1:0] OSOS_DUTY_25 = 2'h1;
  localparam logic [1:0] OSOS_DUTY_12 = 2'h2;
  localparam logic [1:0] OSOS_DUTY_6 = 2'h3;

  // control fields carried together
  typedef struct packed {
    logic [1:0] carrier_duty_select;
    logic optical_carrier_enable;
    logic optical_rx_invert;
    logic optical_tx_invert;
    logic [1:0] optical_tx_pin_enable;
  } osos_ctrl_type;

  // apb request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } osos_apb_req_type;
endpackage : osos_pkg

// ---- src/osos_skid.sv ----
`timescale 1ns/1ns
// two-entry buffer; a receiver stall holds words instead of losing them
module osos_skid
  import osos_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // elaboration check: a word of no bits cannot be buffered
  if (WIDTH < 1) begin : g_bad_width
    $error("osos_skid: WIDTH must be positive");
  end

  // whole state in one struct
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic rd;
    logic wr;
    logic [1:0] cnt;
  } osos_skid_st_type;

  osos_skid_st_type s_q;
  osos_skid_st_type s_d;
  logic push;
  logic pop;

  assign in_ready = (s_q.cnt != 2'h2);
  assign out_valid = (s_q.cnt != 2'h0);
  assign out_data = s_q.mem[s_q.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // next state: write at wr, read at rd, count tracks fill
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr = ~s_q.wr;
    end
    if (pop) begin
      s_d.rd = ~s_q.rd;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 2'h1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 2'h1;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : osos_skid

// ---- src/osos_top.sv ----
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ns
// optical output stage of the second serial port, apb configured
// pin enable, polarity, carrier and duty all come from one control word
module osos_top
  import osos_pkg::*;
#(
  parameter int CARRIER_CYC = OSOS_CARRIER_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_tx_data,
  output logic serial_rx_data,
  input wire logic battery_low_power_state,
  output logic optical_tx_pin,
  output logic optical_tx_pin_oe,
  input wire logic optical_rx_pin,
  output logic rx_word_valid,
  input wire logic rx_word_ready,
  output logic [7:0] rx_word
);
  // elaboration check: the phase counter is 16 bits wide, and the shortest
  // low time (a sixteenth of the period) must last at least one cycle;
  // a shorter period would leave the 6.25% code with no low time at all
  if (CARRIER_CYC < 16 || CARRIER_CYC > 65535) begin : g_bad_period
    $error("osos_top: bad CARRIER_CYC");
  end

  // all block state except the receive buffer's, registered as one word so reset and update stay uniform;
  // the control word keeps the packed layout of bus bits 6:0
  typedef struct packed {
    osos_ctrl_type ctrl; // control word as software last wrote it
    logic [15:0] phase; // position inside the carrier period
    logic [31:0] rdata; // read data, latched in the setup phase
    logic tx_out; // registered optical transmit level
    logic tx_oe; // registered pin drive enable
    logic rx_in; // receive line after polarity selection
    logic [7:0] shift; // receive sampler shift register, oldest sample on top
    logic [2:0] nbits; // samples gathered into the current word
    logic wvalid; // a complete word waits to enter the buffer
  } osos_st_type;

  // registered state and its next value
  osos_st_type s_q;
  osos_st_type s_d;
  // bus side
  osos_apb_req_type req; // apb inputs carried together
  logic wr_en; // access phase of a write
  logic rd_en; // setup phase of a read
  logic known; // address maps to a register
  logic [31:0] stat_word; // status word as a read would return it
  // receive buffer handshake
  logic buf_ready; // buffer has a free entry
  logic buf_valid; // buffer holds a word
  logic [7:0] buf_data; // oldest word in the buffer

  // carrier path
  logic [15:0] low_cyc; // low time of the selected duty code
  logic carrier_on; // carrier applies to the mark level now
  logic carrier_low; // carrier is in the low part of its period
  logic tx_line; // transmit level before polarity selection

  // apb inputs gathered into one bundle
  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  // every access is served at once, so the slave never stretches the access phase
  assign pready = 1'b1; // zero wait states
  // a write takes effect in its access phase
  assign wr_en = req.psel && req.penable && req.pwrite;
  // a read is latched in its setup phase, so prdata comes from a flop in access
  assign rd_en = req.psel && !req.penable && !req.pwrite;

  // address decoding, used only for the error path;
  // the same offsets decide the write and read paths further down
  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == OSOS_CTRL_OFS) || (a == OSOS_STAT_OFS) ||
                 (a == OSOS_TXDATA_OFS) || (a == OSOS_RXDATA_OFS);
  endfunction : addr_known

  // an unmapped address answers with an error in the access phase;
  // writes to read-only registers are ignored without an error
  assign known = addr_known(req.paddr);
  assign pslverr = req.psel && req.penable && !known;

  // status word: room in the buffer, word available, battery state, receive line
  always_comb begin
    stat_word = 32'h0;
    // bit 1 of the room field stays zero: the buffer reports only full or not
    stat_word[OSOS_STAT_SLOTS_LSB +: 2] = {1'b0, buf_ready};
    stat_word[OSOS_STAT_RXVAL_BIT] = buf_valid;
    stat_word[OSOS_STAT_BATT_BIT] = battery_low_power_state;
    stat_word[OSOS_STAT_RX_BIT] = s_q.rx_in;
  end

  // low time for each duty code, as a fraction of the carrier period;
  // the divisors are powers of two, so a short period rounds the low time down
  always_comb begin
    case (s_q.ctrl.carrier_duty_select)
      OSOS_DUTY_50: low_cyc = 16'(CARRIER_CYC / 2); // half the period
      OSOS_DUTY_25: low_cyc = 16'(CARRIER_CYC / 4); // a quarter
      OSOS_DUTY_12: low_cyc = 16'(CARRIER_CYC / 8); // an eighth
      default: low_cyc = 16'(CARRIER_CYC / 16); // a sixteenth
    endcase
  end

  // carrier only with system power; battery state suppresses it
  assign carrier_on = s_q.ctrl.optical_carrier_enable &&
                      !battery_low_power_state;
  // the low part opens each period and lasts the selected time
  assign carrier_low = (s_q.phase < low_cyc);
  // carrier chops only the mark level, so a space stays a steady low
  assign tx_line = serial_tx_data && !(carrier_on && carrier_low);

  // receive words hand over through the two-entry buffer, so a reader that
  // stalls for a while loses no word; the sampler waits while a complete word finds it full
  osos_skid #(.WIDTH(8)) u_skid (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(s_q.wvalid),
    .in_ready(buf_ready),
    .in_data(s_q.shift),
    .out_valid(buf_valid),
    .out_ready(rx_word_ready),
    .out_data(buf_data)
  );

  // receive buffer output
  assign rx_word_valid = buf_valid;
  assign rx_word = buf_data;

  // pins and serial port side, all straight from flops
  assign optical_tx_pin = s_q.tx_out;
  assign optical_tx_pin_oe = s_q.tx_oe;
  assign serial_rx_data = s_q.rx_in;
  // bus read data, a flop that holds until the next read setup
  assign prdata = s_q.rdata;

  // next state: carrier phase, pin levels, receive sampler and register access
  always_comb begin
    // hold everything unless a step below changes it
    s_d = s_q;
    // carrier phase counter free-runs at the 38 kHz period; it is not aligned
    // to serial bit edges, so the first carrier pulse of a mark may be short
    if (s_q.phase >= 16'(CARRIER_CYC - 1)) begin
      // end of the period: start the next one
      s_d.phase = 16'h0000;
    end else begin
      // inside the period: advance
      s_d.phase = s_q.phase + 16'h0001;
    end

    // output polarity and drive enable; both are registered so the pin
    // never glitches while the carrier compare settles
    s_d.tx_out = tx_line ^ s_q.ctrl.optical_tx_invert;
    s_d.tx_oe = (s_q.ctrl.optical_tx_pin_enable == OSOS_TXE_ACTIVE);
    // receive polarity applies before the sampler and the serial port see the line
    s_d.rx_in = optical_rx_pin ^ s_q.ctrl.optical_rx_invert;

    // receive sampler: collects 8 raw line samples for software debug
    if (s_q.wvalid && buf_ready) begin
      // the buffer took the waiting word
      s_d.wvalid = 1'b0;
    end
    // sampling pauses while a word waits on a full buffer, so the waiting word is not overwritten
    if (!s_q.wvalid || buf_ready) begin
      // newest sample enters at the bottom
      s_d.shift = {s_q.shift[6:0], s_q.rx_in};
      s_d.nbits = s_q.nbits + 3'h1;
      if (s_q.nbits == 3'h7) begin
        // eighth sample: the word is complete; this set wins over the clear above
        s_d.wvalid = 1'b1;
      end
    end

    // register writes land in the access phase; only the control word is writable
    if (wr_en) begin
      if (req.paddr == OSOS_CTRL_OFS) begin
        // unused upper bits of the bus word are dropped
        s_d.ctrl = req.pwdata[6:0];
      end
    end
    // read data is prepared in setup and held through access;
    // latching at setup keeps prdata steady for the whole access phase
    if (rd_en) begin
      if (req.paddr == OSOS_CTRL_OFS) begin
        // control word, zero above it
        s_d.rdata = {25'h0, s_q.ctrl};
      end else if (req.paddr == OSOS_STAT_OFS) begin
        // status word
        s_d.rdata = stat_word;
      end else if (req.paddr == OSOS_TXDATA_OFS) begin
        // present level of the transmit data from the serial port
        s_d.rdata = {31'h0, serial_tx_data};
      end else if (req.paddr == OSOS_RXDATA_OFS) begin
        // oldest buffered word; reading does not remove it
        s_d.rdata = {24'h0, buf_data};
      end else begin
        // unmapped address reads as zero
        s_d.rdata = 32'h0;
      end
    end
  end

  // state register; reset leaves the pin undriven and the carrier off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // everything clears except the control word, whose pin field reads 11
      s_q <= '0;
      s_q.ctrl <= OSOS_CTRL_RST;
    end else begin
      // take the next value
      s_q <= s_d;
    end
  end
endmodule : osos_top

// ---- testbench/osos_top_asserts.sv ----
`timescale 1ns/1ns
// shadows the control word from apb writes and watches the optical pins
module osos_top_chk
  import osos_pkg::*;
#(
  parameter int CARRIER_CYC = OSOS_CARRIER_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic serial_tx_data,
  input wire logic serial_rx_data,
  input wire logic battery_low_power_state,
  input wire logic optical_tx_pin,
  input wire logic optical_tx_pin_oe,
  input wire logic optical_rx_pin
);
  logic [6:0] c_q; // control word as software last wrote it
  logic m_q; // carrier due on the pin sample now seen
  int lo_q; // run of carrier low
  int hi_q; // run of carrier high; a carrier that never starts grows it
  // run counters; a space holds the pin steady and would stretch a run, so only mark time counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_q <= OSOS_CTRL_RST;
      m_q <= 1'b0;
      lo_q <= 0;
      hi_q <= 0;
    end else begin
      if (psel && penable && pwrite && paddr == OSOS_CTRL_OFS) c_q <= pwdata[6:0];
      m_q <= c_q[4] && c_q[1:0] == 2'h0 && serial_tx_data && !battery_low_power_state;
      lo_q <= (m_q && optical_tx_pin == c_q[2]) ? lo_q + 1 : 0;
      hi_q <= (m_q && optical_tx_pin != c_q[2]) ? hi_q + 1 : 0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // settings unchanged since the last sample and the pin enabled
  sequence s_on;
    $past(presetn) && $stable(c_q) && c_q[1:0] == 2'h0;
  endsequence
  property p_oe;
    $past(presetn) && $stable(c_q) |-> optical_tx_pin_oe == (c_q[1:0] == OSOS_TXE_ACTIVE);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable mismatch");
  property p_plain;
    s_on ##0 !c_q[4] |-> optical_tx_pin == $past(serial_tx_data ^ c_q[2]);
  endproperty
  a_plain: assert property (p_plain) else $error("plain output mismatch");
  property p_batt;
    s_on ##0 $past(battery_low_power_state) |-> optical_tx_pin == $past(serial_tx_data ^ c_q[2]);
  endproperty
  a_batt: assert property (p_batt) else $error("carrier in battery state");
  property p_space;
    s_on ##0 !$past(serial_tx_data) |-> optical_tx_pin == c_q[2];
  endproperty
  a_space: assert property (p_space) else $error("space level mismatch");
  property p_rx;
    $past(presetn) && $stable(c_q) |-> serial_rx_data == $past(optical_rx_pin ^ c_q[3]);
  endproperty
  a_rx: assert property (p_rx) else $error("receive polarity mismatch");
  property p_duty;
    lo_q <= (CARRIER_CYC >> (32'(c_q[6:5]) + 1)) + 2;
  endproperty
  a_duty: assert property (p_duty) else $error("carrier low too long");
  property p_carrier;
    hi_q <= CARRIER_CYC + 2;
  endproperty
  a_carrier: assert property (p_carrier) else $error("carrier missing");
endmodule : osos_top_chk
bind osos_top osos_top_chk #(.CARRIER_CYC(CARRIER_CYC)) u_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .serial_tx_data, .serial_rx_data,
  .battery_low_power_state, .optical_tx_pin, .optical_tx_pin_oe, .optical_rx_pin);

// ---- testbench/osos_optics.sv ----
`timescale 1ns/1ns
// emitter and photodetector facing the optical pins
module osos_optics (
  input wire logic pclk,
  input wire logic clr,
  input wire logic optical_tx_pin,
  input wire logic optical_tx_pin_oe,
  output logic optical_rx_pin,
  output int lo_n
);
  logic idle_q = 1'b0; // dark emitter: detector line wanders, never holds old data
  // light reaches the detector only while the pin is driven
  assign optical_rx_pin = optical_tx_pin_oe ? optical_tx_pin : idle_q;
  // counts dark cycles of a driven emitter, to measure the carrier duty
  always @(posedge pclk) begin
    idle_q <= !idle_q;
    lo_n <= clr ? 0 : lo_n + 32'(optical_tx_pin_oe && !optical_tx_pin);
  end
endmodule : osos_optics

// ---- testbench/optical_serial_output_stage_test.sv ----
`timescale 1ns/1ns
module optical_serial_output_stage_test
  import osos_pkg::*;
;
  localparam int CYC = 64; // short carrier period keeps the run brief
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, serial_tx_data, battery_low_power_state, clr, re;
  logic rx_word_ready, pready, pslverr, serial_rx_data, optical_tx_pin, optical_tx_pin_oe;
  logic optical_rx_pin, rx_word_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] rx_word;
  int lo_n;
  int err_total = 0;
  int n_checks = 0;
  osos_top #(.CARRIER_CYC(CYC)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .serial_tx_data, .serial_rx_data,
    .battery_low_power_state, .optical_tx_pin, .optical_tx_pin_oe, .optical_rx_pin,
    .rx_word_valid, .rx_word_ready, .rx_word);
  osos_optics u_optics (.pclk, .clr, .optical_tx_pin, .optical_tx_pin_oe, .optical_rx_pin,
    .lo_n);
  initial forever #5 pclk = ~pclk;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one apb transfer; waits for pready, bounded
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      err_total++;
      tally_and_finish;
    end else begin
      rd = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : tick
  task automatic t_reset;
    apb(1'b0, OSOS_CTRL_OFS, 32'h0);
    chk("ctrl", rd, 32'h3);
    chk("oe", 32'(optical_tx_pin_oe), 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", 32'(re), 32'h1);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OSOS_CTRL_OFS, 32'(i));
      tick(3);
      chk("oe", 32'(optical_tx_pin_oe), 32'(i == 0));
    end
    $display("reset and enable done");
  endtask : t_reset
  task automatic t_inv;
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OSOS_CTRL_OFS, 32'(i[2:1]) << 2);
      @(posedge pclk);
      serial_tx_data <= i[0];
      tick(3);
      chk("tx pin", 32'(optical_tx_pin), 32'(i[0] ^ i[1]));
      chk("rx", 32'(serial_rx_data), 32'(i[0] ^ i[1] ^ i[2]));
    end
    $display("inversion done");
  endtask : t_inv
  // code 4 stands for 50% duty in the battery state
  task automatic t_duty;
    for (int d = 0; d < 5; d++) begin
      @(posedge pclk);
      serial_tx_data <= 1'b0;
      battery_low_power_state <= (d == 4);
      apb(1'b1, OSOS_CTRL_OFS, (32'(d % 4) << 5) | 32'h10);
      @(posedge pclk);
      serial_tx_data <= 1'b1;
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      tick(4 * CYC);
      chk("lows", lo_n, d == 4 ? 0 : (4 * CYC) >> (d + 1));
    end
    $display("duty done");
  endtask : t_duty
  // buffer filled while the reader stalled; drained, then refilled from a steady mark line
  task automatic t_buf;
    apb(1'b0, OSOS_STAT_OFS, 32'h0);
    chk("stat", rd & 32'h5, 32'h4);
    apb(1'b1, OSOS_CTRL_OFS, 32'h0);
    @(posedge pclk);
    rx_word_ready <= 1'b1;
    tick(40);
    // stall again so only words of the steady line remain, and valid stands
    @(posedge pclk);
    rx_word_ready <= 1'b0;
    tick(40);
    chk("word", {31'h0, rx_word_valid} << 8 | 32'(rx_word), 32'h1FF);
    apb(1'b0, OSOS_RXDATA_OFS, 32'h0);
    chk("rxdata", rd, 32'hFF);
    // full buffer, word waiting, battery state still set, receive line high
    apb(1'b0, OSOS_STAT_OFS, 32'h0);
    chk("stat full", rd & 32'h1D, 32'h1C);
    apb(1'b0, OSOS_TXDATA_OFS, 32'h0);
    chk("txdata", rd, 32'h1);
    $display("buffer done");
  endtask : t_buf
  // reset in mid-run returns the control word and the pin drive to reset values
  task automatic t_rst;
    @(posedge pclk);
    presetn <= 1'b0;
    tick(2);
    chk("oe in reset", 32'(optical_tx_pin_oe), 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OSOS_CTRL_OFS, 32'h0);
    chk("ctrl after reset", rd, 32'h3);
    chk("oe after reset", 32'(optical_tx_pin_oe), 32'h0);
    $display("mid-run reset done");
  endtask : t_rst
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    serial_tx_data = 1'b1;
    battery_low_power_state = 1'b0;
    rx_word_ready = 1'b0;
    clr = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_inv;
    t_duty;
    t_buf;
    t_rst;
    tally_and_finish;
  end
endmodule : optical_serial_output_stage_test
